// *** inc/margin_pkg.sv ***
// shared constants for the margining converter code control block
package margin_pkg;

  localparam int NUM_CHANNELS = 6;
  localparam int CODE_W = 8;
  localparam int LEVEL_W = 21;
  localparam int ADDR_W = 8;

  localparam logic [CODE_W-1:0] MIDCODE = 8'h7F;
  localparam logic [CODE_W-1:0] CODE_FULL_SCALE = 8'hFF;
  localparam int CODES_UP = 128;
  localparam int CODES_DOWN = 127;

  // converter span over the full code range, in microvolts
  localparam int SPAN_UV = 601500;
  localparam int SPAN_DIVISOR = 255;

  // midcode offsets, in microvolts
  localparam int OFFSET_0P60_UV = 600000;
  localparam int OFFSET_0P80_UV = 800000;
  localparam int OFFSET_1P00_UV = 1000000;
  localparam int OFFSET_1P25_UV = 1250000;

  typedef enum logic [1:0] {
    RANGE_0P60 = 2'b00,
    RANGE_0P80 = 2'b01,
    RANGE_1P00 = 2'b10,
    RANGE_1P25 = 2'b11
  } midcode_range_t;

  typedef enum logic [1:0] {
    BUF_OFF = 2'b00,
    BUF_TRACK = 2'b01,
    BUF_DRIVE = 2'b10
  } buffer_state_t;

  // register groups: address bits [7:3] pick the group, [2:0] the channel
  localparam logic [4:0] GROUP_CODE = 5'h00;
  localparam logic [4:0] GROUP_UPPER = 5'h01;
  localparam logic [4:0] GROUP_LOWER = 5'h02;
  localparam logic [4:0] GROUP_CONFIG = 5'h03;
  localparam logic [4:0] GROUP_APPLIED = 5'h04;
  localparam logic [4:0] GROUP_STATUS = 5'h05;

  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_RANGE_LSB = 1;
  localparam int STATUS_TRACK_BIT = 0;
  localparam int STATUS_DRIVE_BIT = 1;
  localparam int STATUS_INVERTED_BIT = 2;

  localparam logic [CODE_W-1:0] RESET_CODE = MIDCODE;
  localparam logic [CODE_W-1:0] RESET_UPPER = 8'hFF;
  localparam logic [CODE_W-1:0] RESET_LOWER = 8'h00;
  localparam logic [CODE_W-1:0] RESET_CONFIG = 8'h00;
  localparam logic [CODE_W-1:0] UNMAPPED_READ = 8'h00;

  // buffer settle time while following the pin, before it drives
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TRACK_TIME_NS = 2000;
  localparam int TRACK_CYCLES = (TRACK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  function automatic int offset_uv(input midcode_range_t sel);
    int v;
    v = OFFSET_0P60_UV;
    unique case (sel)
      RANGE_0P60: v = OFFSET_0P60_UV;
      RANGE_0P80: v = OFFSET_0P80_UV;
      RANGE_1P00: v = OFFSET_1P00_UV;
      RANGE_1P25: v = OFFSET_1P25_UV;
    endcase
    return v;
  endfunction

endpackage

// *** design/margin_channel.sv ***
// one margining channel: code clipping, level model and buffer enable sequence
`timescale 1ns/100ps
module margin_channel
  import margin_pkg::*;
#(
  parameter int TRACK_COUNT = TRACK_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [margin_pkg::CODE_W-1:0] code,
  input wire logic [margin_pkg::CODE_W-1:0] upper_limit,
  input wire logic [margin_pkg::CODE_W-1:0] lower_limit,
  input wire logic enable,
  input wire margin_pkg::midcode_range_t range_sel,
  output logic [margin_pkg::CODE_W-1:0] applied_code,
  output logic [margin_pkg::LEVEL_W-1:0] level_uv,
  output logic buffer_power,
  output logic buffer_from_dac,
  output logic buffer_drive,
  output logic limits_inverted
);

  localparam int CNT_W = $clog2(TRACK_COUNT + 1);

  if (TRACK_COUNT < 1)
    $error("track count must be at least one cycle");

  buffer_state_t state;
  buffer_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CODE_W-1:0] next_applied;
  logic [LEVEL_W-1:0] next_level;
  wire inverted = lower_limit > upper_limit;
  wire want_on = enable && !inverted;
  wire track_done = count == CNT_W'(TRACK_COUNT - 1);

  // clip to the inclusive limit window
  assign next_applied = (code < lower_limit) ? lower_limit :
                        (code > upper_limit) ? upper_limit : code;

  always_comb
  begin
    int diff;
    int lvl;
    diff = int'(next_applied) - int'(MIDCODE);
    lvl = (diff * SPAN_UV) / SPAN_DIVISOR + offset_uv(range_sel);
    next_level = LEVEL_W'(lvl);
  end

  always_comb
  begin
    next_state = state;
    next_count = '0;
    unique case (state)
      BUF_OFF:
        if (want_on)
          next_state = BUF_TRACK;
      BUF_TRACK:
        if (!want_on)
          next_state = BUF_OFF;
        else if (track_done)
          next_state = BUF_DRIVE;
        else
          next_count = count + 1'b1;
      BUF_DRIVE:
        if (!want_on)
          next_state = BUF_OFF;
      default:
        next_state = BUF_OFF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= BUF_OFF;
      count <= '0;
      applied_code <= RESET_CODE;
      level_uv <= '0;
      buffer_power <= 1'b0;
      buffer_from_dac <= 1'b0;
      buffer_drive <= 1'b0;
      limits_inverted <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      applied_code <= next_applied;
      level_uv <= next_level;
      buffer_power <= next_state != BUF_OFF;
      buffer_from_dac <= next_state == BUF_DRIVE;
      buffer_drive <= next_state == BUF_DRIVE;
      limits_inverted <= inverted;
    end
  end

endmodule

// *** design/margin_dac_code_control.sv ***
// six-channel margining converter code control with register file and startup load
// Operation
// - six independent margining channels, each driving its own feedback node
// - each channel takes an 8-bit unsigned code, 256 settings
// - level is linear in code; code 0x7F gives the midcode voltage
// - four midcode ranges per channel: 0.6, 0.8, 1.0 and 1.25 V
// - level = (code - 0x7F) / 255 * 0.6015 V + range offset
// - swing is 128 codes up and 127 codes down from midcode
// - applied code is the written code clipped to lower and upper limits
// - lower limit above upper limit holds the buffer three-stated
// - limits are loaded from nonvolatile storage during startup
// - buffer first follows the pin, then switches to the converter and drives
// - a host code write updates that channel's output
`timescale 1ns/100ps
module margin_dac_code_control
  import margin_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS,
  parameter int TRACK_COUNT = TRACK_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic host_write,
  input wire logic host_read,
  input wire logic [margin_pkg::ADDR_W-1:0] host_addr,
  input wire logic [margin_pkg::CODE_W-1:0] host_wdata,
  output logic [margin_pkg::CODE_W-1:0] host_rdata,
  output logic host_rvalid,
  output logic host_refused,
  input wire logic nvm_valid,
  input wire logic [margin_pkg::ADDR_W-1:0] nvm_addr,
  input wire logic [margin_pkg::CODE_W-1:0] nvm_data,
  input wire logic nvm_done,
  output logic config_ready,
  output logic [CHANNELS*margin_pkg::CODE_W-1:0] margin_output_code,
  output logic [CHANNELS*margin_pkg::LEVEL_W-1:0] margin_output_level_uv,
  output logic [CHANNELS-1:0] buffer_power,
  output logic [CHANNELS-1:0] buffer_from_dac,
  output logic [CHANNELS-1:0] buffer_drive,
  output logic [CHANNELS-1:0] limits_inverted
);

  if (CHANNELS < 1 || CHANNELS > 8)
    $error("channel count must be between one and eight");

  // midcode must leave 128 codes of swing up and 127 down
  if (int'(CODE_FULL_SCALE) - int'(MIDCODE) != CODES_UP || int'(MIDCODE) != CODES_DOWN)
    $error("midcode does not split the code range as required");

  logic [CODE_W-1:0] margin_code [CHANNELS];
  logic [CODE_W-1:0] margin_upper_limit [CHANNELS];
  logic [CODE_W-1:0] margin_lower_limit [CHANNELS];
  logic [CODE_W-1:0] channel_config [CHANNELS];
  logic [CODE_W-1:0] applied [CHANNELS];
  logic [CODE_W-1:0] status [CHANNELS];

  // host writes are refused until the startup load completes
  wire host_wr_ok = host_write && config_ready;
  wire load_wr = nvm_valid && !config_ready;
  wire wr_en = host_wr_ok || load_wr;
  wire [ADDR_W-1:0] wr_addr = load_wr ? nvm_addr : host_addr;
  wire [CODE_W-1:0] wr_data = load_wr ? nvm_data : host_wdata;
  wire [4:0] wr_group = wr_addr[7:3];
  wire [2:0] wr_index = wr_addr[2:0];
  wire [4:0] rd_group = host_addr[7:3];
  wire [2:0] rd_index = host_addr[2:0];
  wire rd_in_range = 32'(rd_index) < CHANNELS;
  wire refuse_now = (host_write || host_read) && !config_ready;

  logic [CODE_W-1:0] next_rdata;

  always_comb
  begin
    next_rdata = UNMAPPED_READ;
    if (rd_in_range)
    begin
      unique case (rd_group)
        GROUP_CODE: next_rdata = margin_code[rd_index];
        GROUP_UPPER: next_rdata = margin_upper_limit[rd_index];
        GROUP_LOWER: next_rdata = margin_lower_limit[rd_index];
        GROUP_CONFIG: next_rdata = channel_config[rd_index];
        GROUP_APPLIED: next_rdata = applied[rd_index];
        GROUP_STATUS: next_rdata = status[rd_index];
        default: next_rdata = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      config_ready <= 1'b0;
    else if (nvm_done)
      config_ready <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      host_rdata <= UNMAPPED_READ;
      host_rvalid <= 1'b0;
      host_refused <= 1'b0;
    end
    else
    begin
      host_rvalid <= host_read && config_ready;
      host_refused <= refuse_now;
      if (host_read && config_ready)
        host_rdata <= next_rdata;
    end
  end

  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_chan
    wire hit = wr_en && (32'(wr_index) == ch);

    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        margin_code[ch] <= RESET_CODE;
        margin_upper_limit[ch] <= RESET_UPPER;
        margin_lower_limit[ch] <= RESET_LOWER;
        channel_config[ch] <= RESET_CONFIG;
      end
      else if (hit)
      begin
        if (wr_group == GROUP_CODE)
          margin_code[ch] <= wr_data;
        if (wr_group == GROUP_UPPER)
          margin_upper_limit[ch] <= wr_data;
        if (wr_group == GROUP_LOWER)
          margin_lower_limit[ch] <= wr_data;
        if (wr_group == GROUP_CONFIG)
          channel_config[ch] <= {5'h00, wr_data[2:0]};
      end
    end

    wire midcode_range_t range_sel = midcode_range_t'(channel_config[ch][CFG_RANGE_LSB +: 2]);
    logic [LEVEL_W-1:0] level;
    logic pwr;
    logic from_dac;
    logic drive;
    logic inv;

    // one converter channel per output pin
    margin_channel #(
      .TRACK_COUNT(TRACK_COUNT)
    ) u_channel (
      .clk(clk),
      .reset(reset),
      .code(margin_code[ch]),
      .upper_limit(margin_upper_limit[ch]),
      .lower_limit(margin_lower_limit[ch]),
      .enable(channel_config[ch][CFG_ENABLE_BIT] && config_ready),
      .range_sel(range_sel),
      .applied_code(applied[ch]),
      .level_uv(level),
      .buffer_power(pwr),
      .buffer_from_dac(from_dac),
      .buffer_drive(drive),
      .limits_inverted(inv)
    );

    assign status[ch] = {5'h00, inv, drive, pwr};
    assign margin_output_code[ch*CODE_W +: CODE_W] = applied[ch];
    assign margin_output_level_uv[ch*LEVEL_W +: LEVEL_W] = level;
    assign buffer_power[ch] = pwr;
    assign buffer_from_dac[ch] = from_dac;
    assign buffer_drive[ch] = drive;
    assign limits_inverted[ch] = inv;
  end

endmodule

// *** verification/margin_dac_code_control_assertions.sv ***
// assertion checker for the margining code control block
`timescale 1ns/100ps
module margin_dac_code_control_checker #(parameter int CHANNELS = 6, parameter int TRACK_COUNT = 3)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic host_write,
  input wire logic host_read,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic host_refused,
  input wire logic config_ready,
  input wire logic [CHANNELS-1:0] buffer_power,
  input wire logic [CHANNELS-1:0] buffer_from_dac,
  input wire logic [CHANNELS-1:0] buffer_drive,
  input wire logic [CHANNELS-1:0] limits_inverted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_refuse; (host_write || host_read) && !config_ready |=> host_refused; endproperty
  a_refuse: assert property (p_refuse) else $error("early access not refused");
  property p_ready_holds; config_ready |=> config_ready; endproperty
  a_ready_holds: assert property (p_ready_holds) else $error("ready dropped");
  property p_read_answer; host_read && config_ready |=> host_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read unanswered");
  property p_rdata_hold; $changed(host_rdata) |-> host_rvalid; endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_inverted_off; (buffer_power & limits_inverted) == '0; endproperty
  a_inverted_off: assert property (p_inverted_off) else $error("buffer on, limits inverted");
  property p_track_first; $rose(buffer_power[0]) |-> !buffer_from_dac[0] && !buffer_drive[0];
  endproperty
  a_track_first: assert property (p_track_first) else $error("buffer drove at power up");
  property p_drive_after_track;
    $rose(buffer_drive[0]) |-> $past(buffer_power[0], TRACK_COUNT) && buffer_from_dac[0];
  endproperty
  a_drive_after_track: assert property (p_drive_after_track) else $error("short tracking");
  property p_drive_pairs;
    (buffer_drive == buffer_from_dac) && ((buffer_drive & ~buffer_power) == '0);
  endproperty
  a_drive_pairs: assert property (p_drive_pairs) else $error("drive without input switch");
  c_refused: cover property (host_refused);
  c_drive: cover property ($rose(buffer_drive[0]));
  c_inverted: cover property (limits_inverted[1]);
  c_uninverted_on: cover property ($rose(buffer_power[1]));
endmodule
bind margin_dac_code_control margin_dac_code_control_checker #(.CHANNELS(CHANNELS),
  .TRACK_COUNT(TRACK_COUNT)) u_checker (.clk(clk), .reset(reset), .host_write(host_write),
  .host_read(host_read), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
  .host_refused(host_refused), .config_ready(config_ready), .buffer_power(buffer_power),
  .buffer_from_dac(buffer_from_dac), .buffer_drive(buffer_drive),
  .limits_inverted(limits_inverted));

// *** verification/margin_host_model.sv ***
// host side model: startup load, register writes and reads
`timescale 1ns/100ps
module margin_host_model
(
  input wire logic clk,
  output logic host_write = 1'h0,
  output logic host_read = 1'h0,
  output logic [7:0] host_addr = 8'hA5,
  output logic [7:0] host_wdata = 8'h5A,
  input wire logic [7:0] host_rdata,
  output logic nvm_valid = 1'h0,
  output logic nvm_done = 1'h0,
  output logic [7:0] nvm_addr = 8'h3C,
  output logic [7:0] nvm_data = 8'hC3
);
  // released address and data lines show the inverse, never the last value
  task automatic nvm(input logic v, input logic dn, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    nvm_valid <= v;
    nvm_done <= dn;
    nvm_addr <= a;
    nvm_data <= d;
    @(posedge clk);
    nvm_valid <= 1'h0;
    nvm_done <= 1'h0;
    nvm_addr <= ~a;
    nvm_data <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host_write <= 1'h1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_write <= 1'h0;
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    host_read <= 1'h1;
    host_addr <= a;
    @(posedge clk);
    host_read <= 1'h0;
    host_addr <= ~a;
    #1 d = host_rdata;
  endtask
  // off, code matched to feedback, then on
  task automatic margin_start(input logic [2:0] ch, input logic [7:0] c, input logic [7:0] cfg);
    wr({5'h03, ch}, 8'h00);
    wr({5'h00, ch}, c);
    wr({5'h03, ch}, cfg);
  endtask
endmodule

// *** verification/margin_dac_code_control_tb_top.sv ***
// self-checking bench for the margining code control block
`timescale 1ns/100ps
module margin_dac_code_control_tb_top;
  import margin_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic host_write, host_read, host_rvalid, host_refused, nvm_valid, nvm_done, config_ready;
  logic [7:0] host_addr, host_wdata, host_rdata, nvm_addr, nvm_data, got, c;
  logic [1:0] r;
  logic [47:0] oc;
  logic [125:0] ol;
  logic [5:0] pwr, dac, drv, inv;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 37;
  logic [7:0] corner [7] = '{8'h00, 8'hFF, 8'h7F, 8'h40, 8'hC0, 8'h3F, 8'hC1};
  logic [7:0] ra [9] = '{8'h02, 8'h0A, 8'h12, 8'h1A, 8'h30, 8'h06, 8'h08, 8'h11, 8'h22};
  logic [7:0] rv [9] = '{8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h90, 8'h7F};
  always #2.5 clk = ~clk;
  margin_host_model host (.clk(clk), .host_write(host_write), .host_read(host_read),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .nvm_valid(nvm_valid), .nvm_done(nvm_done), .nvm_addr(nvm_addr), .nvm_data(nvm_data));
  margin_dac_code_control #(.TRACK_COUNT(3)) dut (.clk(clk), .reset(reset),
    .host_write(host_write), .host_read(host_read), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .host_refused(host_refused), .nvm_valid(nvm_valid), .nvm_addr(nvm_addr),
    .nvm_data(nvm_data), .nvm_done(nvm_done), .config_ready(config_ready),
    .margin_output_code(oc), .margin_output_level_uv(ol), .buffer_power(pwr),
    .buffer_from_dac(dac), .buffer_drive(drv), .limits_inverted(inv));
  function automatic logic [7:0] clip(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic [20:0] level(logic [7:0] v, logic [1:0] s);
    int off [4] = '{600000, 800000, 1000000, 1250000};
    return 21'(off[s] + (int'(v) - 127) * 601500 / 255);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    host.wr(8'h00, 8'h11);
    #1 check(host_refused, 1'h1);
    host.nvm(1'h1, 1'h0, 8'h08, 8'hC0);
    host.nvm(1'h1, 1'h0, 8'h10, 8'h40);
    host.nvm(1'h1, 1'h0, 8'h09, 8'h80);
    host.nvm(1'h1, 1'h0, 8'h11, 8'h90);
    host.nvm(1'h0, 1'h1, 8'h00, 8'h00);
    host.wr(8'h22, 8'h55);
    for (int i = 0; i < 9; i++)
    begin
      host.rd(ra[i], got);
      check(got, rv[i]);
    end
    host.margin_start(3'h0, 8'h7F, 8'h01);
    @(posedge clk);
    #1 check({pwr[0], dac[0], drv[0]}, 3'h4);
    repeat (2) @(posedge clk);
    #1 check(drv[0], 1'h0);
    @(posedge clk);
    #1 check({pwr[0], dac[0], drv[0]}, 3'h7);
    host.rd(8'h28, got);
    check(got, 8'h03);
    host.wr(8'h19, 8'h01);
    repeat (5) @(posedge clk);
    #1 check({inv[1], pwr[1], drv[1], oc[15:8]}, 11'h490);
    host.rd(8'h29, got);
    check(got, 8'h04);
    host.wr(8'h11, 8'h70);
    @(posedge clk);
    #1 check({inv[1], pwr[1], oc[15:8]}, 10'h17F);
    for (int i = 0; i < 40; i++)
    begin
      c = (i < 7) ? corner[i] : 8'($random(seed));
      r = 2'($random(seed));
      host.wr(8'h18, {5'h00, r, 1'h1});
      host.wr(8'h00, c);
      @(posedge clk);
      #1 check(oc[7:0], clip(c, 8'h40, 8'hC0));
      check(ol[20:0], level(clip(c, 8'h40, 8'hC0), r));
    end
    for (int i = 0; i < 12; i++)
    begin
      host.wr(8'h1A, {5'h00, 2'(i / 3), 1'h0});
      host.wr(8'h02, corner[i % 3]);
      @(posedge clk);
      #1 check(ol[62:42], level(corner[i % 3], 2'(i / 3)));
    end
    for (int ch = 2; ch < 6; ch++)
    begin
      c = 8'($random(seed));
      host.wr(8'(ch), c);
      @(posedge clk);
      #1 check(oc[8*ch+:8], c);
    end
    host.wr(8'h18, 8'h00);
    @(posedge clk);
    #1 check({pwr[0], dac[0], drv[0]}, 3'h0);
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    #1 check({config_ready, host_rvalid, host_refused, inv, pwr, oc[15:8]}, 23'h00007F);
    tally_and_finish();
  end
endmodule
